// File: inc/rti_bus_if.sv
// Two-wire open-drain bus joining the master end and the target end.
// Assumes pull-ups: a line is low only while some end drives it low.
`timescale 1ns/1ps
`default_nettype none
interface rti_bus_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic t_sda_o;
	logic t_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND with pull-up: released lines read high.
	assign scl = !(m_scl_oe && !m_scl_o);
	assign sda = !((m_sda_oe && !m_sda_o) || (t_sda_oe && !t_sda_o));

	modport master (
		output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe,
		input scl, sda
	);
	modport target (
		output t_sda_o, t_sda_oe,
		input scl, sda
	);
endinterface
`default_nettype wire

// File: inc/rti_pkg.sv
// Shared constants and types for the two-wire clock/calendar target link.
// Assumes both ends and the bench import it; holds no logic.
package rti_pkg;

	// Fixed 7-bit target address; with the direction bit it gives d1/d0.
	localparam logic [6:0] RTI_TARGET_ADDR = 7'h68;
	// Direction bit value that selects a read.
	localparam logic RTI_DIR_READ = 1'b1;
	// Bits in one byte on the wire.
	localparam logic [3:0] RTI_BYTE_BITS = 4'h8;
	// Locations reserved for factory test; masters keep away from them.
	localparam logic [7:0] RTI_TEST_LOC_A = 8'h49;
	localparam logic [7:0] RTI_TEST_LOC_B = 8'h4a;
	// Master clock period and bus clock period, both in ns.
	localparam int RTI_MCLK_PERIOD_NS = 5;
	localparam int RTI_SCL_PERIOD_NS = 2500;
	// Master cycles per quarter of a bus clock period, rounded down.
	localparam int RTI_SCL_QTR_CYC =
		RTI_SCL_PERIOD_NS / (4 * RTI_MCLK_PERIOD_NS);

	// Commands that the master's user side may issue.
	typedef enum logic [1:0] {
		RTI_CMD_START,
		RTI_CMD_STOP,
		RTI_CMD_WRITE,
		RTI_CMD_READ
	} rti_cmd_e;

endpackage

// File: rtl/rti_master.sv
// Master end of the two-wire link: makes SCL from mclk_i by a divider.
// Assumes a user side that issues start, byte and stop commands in a legal
// order and keeps away from the reserved test locations.
`timescale 1ns/1ps
`default_nettype none
module rti_master
	import rti_pkg::*;
#(
	parameter logic [15:0] QTR_CYC = 16'(RTI_SCL_QTR_CYC)
) (
	input wire logic mclk_i, // System clock.
	input wire logic rstn_i, // Asynchronous reset, active low.
	rti_bus_if.master bus, // Two-wire bus.
	input wire logic cmd_valid_i, // Command offered.
	input wire rti_cmd_e cmd_i, // Command code.
	input wire logic [7:0] cmd_data_i, // Byte to write.
	input wire logic cmd_ack_i, // Acknowledge the byte read.
	output logic cmd_ready_o, // Ready for a command.
	output logic rsp_valid_o, // Command done, one cycle.
	output logic [7:0] rsp_data_o, // Byte read.
	output logic rsp_nack_o // Ninth bit was high.
);

	typedef enum logic [1:0] {
		M_IDLE,
		M_COND,
		M_BIT
	} rti_mstate_e;

	logic [2:0] sda_sync_reg;
	logic [2:0] sda_sync_next;
	logic sda_f_reg;
	logic sda_f_next;

	rti_mstate_e st_reg;
	rti_mstate_e st_next;
	rti_cmd_e cmd_reg;
	rti_cmd_e cmd_next;
	logic [15:0] tcnt_reg;
	logic [15:0] tcnt_next;
	logic [1:0] q_reg;
	logic [1:0] q_next;
	logic [3:0] bit_reg;
	logic [3:0] bit_next;
	logic [8:0] out_reg;
	logic [8:0] out_next;
	logic [8:0] in_reg;
	logic [8:0] in_next;
	logic scl_oe_reg;
	logic scl_oe_next;
	logic sda_oe_reg;
	logic sda_oe_next;
	logic ready_reg;
	logic ready_next;
	logic rsp_valid_reg;
	logic rsp_valid_next;
	logic [7:0] rsp_data_reg;
	logic [7:0] rsp_data_next;
	logic rsp_nack_reg;
	logic rsp_nack_next;
	logic tick;
	logic done;

	// SDA comes from the target's clock domain, so it is filtered.
	always_comb begin
		sda_sync_next = {sda_sync_reg[1:0], bus.sda};
		sda_f_next = sda_f_reg;
		if (sda_sync_reg[1] == sda_sync_reg[2]) begin
			sda_f_next = sda_sync_reg[2];
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sda_sync_reg <= 3'h7;
			sda_f_reg <= 1'b1;
		end else begin
			sda_sync_reg <= sda_sync_next;
			sda_f_reg <= sda_f_next;
		end
	end

	assign tick = (tcnt_reg == QTR_CYC - 16'h0001);

	// Each step acts at the end of a quarter SCL period.
	always_comb begin
		st_next = st_reg;
		cmd_next = cmd_reg;
		tcnt_next = tcnt_reg;
		q_next = q_reg;
		bit_next = bit_reg;
		out_next = out_reg;
		in_next = in_reg;
		scl_oe_next = scl_oe_reg;
		sda_oe_next = sda_oe_reg;
		ready_next = ready_reg;
		rsp_valid_next = 1'b0;
		rsp_data_next = rsp_data_reg;
		rsp_nack_next = rsp_nack_reg;
		done = 1'b0;
		if (st_reg != M_IDLE) begin
			tcnt_next = tick ? 16'h0000 : tcnt_reg + 16'h0001;
			q_next = tick ? q_reg + 2'h1 : q_reg;
		end
		case (st_reg)
		M_IDLE: begin
			// Idle means ready; taking a command lowers it again below.
			ready_next = 1'b1;
			if (cmd_valid_i && ready_reg) begin
				ready_next = 1'b0;
				cmd_next = cmd_i;
				tcnt_next = 16'h0000;
				q_next = 2'h0;
				bit_next = 4'h0;
				st_next = M_COND;
				if (cmd_i == RTI_CMD_WRITE) begin
					out_next = {cmd_data_i, 1'b1}; // RL4 RL10
					st_next = M_BIT;
				end else if (cmd_i == RTI_CMD_READ) begin
					out_next = {8'hff, !cmd_ack_i}; // RL9 RL12
					st_next = M_BIT;
				end
			end
		end
		M_COND: begin
			if (tick) begin
				if (cmd_reg == RTI_CMD_START) begin
					// Release both, then pull SDA with SCL high, then SCL.
					case (q_reg)
					2'h0: sda_oe_next = 1'b0;
					2'h1: scl_oe_next = 1'b0;
					2'h2: sda_oe_next = 1'b1; // RL1 RL3
					default: begin
						scl_oe_next = 1'b1;
						done = 1'b1;
					end
					endcase
				end else begin
					case (q_reg)
					2'h0: sda_oe_next = 1'b1;
					2'h1: scl_oe_next = 1'b0;
					2'h2: sda_oe_next = 1'b0; // RL2
					default: done = 1'b1; // RL18
					endcase
				end
			end
		end
		M_BIT: begin
			if (tick) begin
				case (q_reg)
				2'h0: sda_oe_next = !out_reg[8]; // RL7
				2'h1: scl_oe_next = 1'b0;
				2'h2: in_next = {in_reg[7:0], sda_f_reg}; // RL7
				default: begin
					scl_oe_next = 1'b1;
					out_next = {out_reg[7:0], 1'b1};
					bit_next = bit_reg + 4'h1;
					if (bit_reg == RTI_BYTE_BITS) begin
						// Let go of our acknowledge on the ninth fall.
						sda_oe_next = 1'b0; // RL11
						done = 1'b1;
					end
				end
				endcase
			end
		end
		default: begin
			st_next = M_IDLE;
		end
		endcase
		if (done) begin
			st_next = M_IDLE;
			ready_next = 1'b1;
			rsp_valid_next = 1'b1;
			rsp_data_next = in_reg[8:1];
			rsp_nack_next = in_reg[0]; // RL9
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_reg <= M_IDLE;
			cmd_reg <= RTI_CMD_START;
			tcnt_reg <= 16'h0000;
			q_reg <= 2'h0;
			bit_reg <= 4'h0;
			out_reg <= 9'h1ff;
			in_reg <= 9'h000;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			ready_reg <= 1'b0;
			rsp_valid_reg <= 1'b0;
			rsp_data_reg <= 8'h00;
			rsp_nack_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cmd_reg <= cmd_next;
			tcnt_reg <= tcnt_next;
			q_reg <= q_next;
			bit_reg <= bit_next;
			out_reg <= out_next;
			in_reg <= in_next;
			scl_oe_reg <= scl_oe_next;
			sda_oe_reg <= sda_oe_next;
			ready_reg <= ready_next;
			rsp_valid_reg <= rsp_valid_next;
			rsp_data_reg <= rsp_data_next;
			rsp_nack_reg <= rsp_nack_next;
		end
	end

	// Open-drain drivers: pull low or release.
	assign bus.m_scl_o = 1'b0; // RL18
	assign bus.m_scl_oe = scl_oe_reg;
	assign bus.m_sda_o = 1'b0; // RL18
	assign bus.m_sda_oe = sda_oe_reg;
	assign cmd_ready_o = ready_reg;
	assign rsp_valid_o = rsp_valid_reg;
	assign rsp_data_o = rsp_data_reg;
	assign rsp_nack_o = rsp_nack_reg;

endmodule
`default_nettype wire

// File: rtl/rti_target.sv
// Target end of the two-wire link: address match, byte transfer, pointer.
// Assumes it runs on the link clock, fast enough to oversample the bus,
// and that mem_rdata_i follows mem_addr_o within one link clock cycle.
// Rules of the link; this block does the target's part of each.
// RL1: SDA falling with SCL high starts transaction.
// RL2: SDA rising with SCL high ends transaction.
// RL3: Repeated start behaves as start, new address.
// RL4: Bytes of eight bits, most significant first.
// RL5: Any number of bytes per transaction.
// RL6: Pointer advances after every data byte.
// RL7: Change data while SCL low, sample high.
// RL8: SDA change while SCL high is condition.
// RL9: Receiver acknowledges each byte by driving low.
// RL10: After eighth falling edge, receiver drives acknowledge.
// RL11: Master releases acknowledge, target sends next byte.
// RL12: Master withholds acknowledge after last read byte.
// RL13: After no acknowledge, target stays released.
// RL14: Respond only to own seven-bit address.
// RL15: Address byte is d1 read, d0 write.
// RL16: Direction one reads, zero writes.
// RL17: Master avoids test locations 49h and 4ah.
// RL18: Open-drain lines, idle high by pull-up.
// RL19: First written byte loads pointer, rest stored.
// RL20: Read without pointer byte starts at pointer.
// RL21: Stop or start drops partial byte, awaits address.
`timescale 1ns/1ps
`default_nettype none
module rti_target
	import rti_pkg::*;
#(
	parameter logic [6:0] OWN_ADDR = RTI_TARGET_ADDR
) (
	input wire logic lclk_i, // Link clock.
	input wire logic rstn_i, // Asynchronous reset, active low.
	rti_bus_if.target bus, // Two-wire bus.
	output logic [7:0] mem_addr_o, // Location pointer.
	output logic [7:0] mem_wdata_o, // Byte to store.
	output logic mem_we_o, // Store strobe, one cycle.
	output logic mem_re_o, // Fetch strobe, one cycle.
	input wire logic [7:0] mem_rdata_i, // Byte at mem_addr_o.
	output logic busy_o // Bus transaction in progress.
);
	typedef enum logic [2:0] {
		T_IDLE,
		T_RX,
		T_ACK,
		T_TX,
		T_RACK
	} rti_tstate_e;
	// Bus samplers: three stages, bit 0 is the first flip-flop.
	logic [2:0] scl_sync_reg, scl_sync_next;
	logic [2:0] sda_sync_reg, sda_sync_next;
	logic scl_f_reg, scl_f_next;
	logic sda_f_reg, sda_f_next;
	logic scl_p_reg, sda_p_reg;
	// Transfer state.
	rti_tstate_e st_reg, st_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] sh_reg, sh_next;
	logic [7:0] ptr_reg, ptr_next;
	logic first_reg, first_next;
	logic rd_reg, rd_next;
	logic ptrph_reg, ptrph_next;
	logic wrote_reg, wrote_next;
	logic mack_reg, mack_next;
	logic drive_reg, drive_next;
	logic we_reg, we_next;
	logic re_reg, re_next;
	logic [7:0] wdata_reg, wdata_next;
	logic busy_reg, busy_next;
	logic scl_rise, scl_fall, start_ev, stop_ev, load_tx;
	// A level moves only once stages two and three agree; glitches die.
	always_comb begin
		scl_sync_next = {scl_sync_reg[1:0], bus.scl};
		sda_sync_next = {sda_sync_reg[1:0], bus.sda};
		scl_f_next = scl_f_reg;
		sda_f_next = sda_f_reg;
		if (scl_sync_reg[1] == scl_sync_reg[2]) begin
			scl_f_next = scl_sync_reg[2];
		end
		if (sda_sync_reg[1] == sda_sync_reg[2]) begin
			sda_f_next = sda_sync_reg[2];
		end
	end
	// Sampler registers; idle bus is high, so reset to high.
	always_ff @(posedge lclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			scl_f_reg <= 1'b1; // RL18
			sda_f_reg <= 1'b1; // RL18
			scl_p_reg <= 1'b1;
			sda_p_reg <= 1'b1;
		end else begin
			scl_sync_reg <= scl_sync_next;
			sda_sync_reg <= sda_sync_next;
			scl_f_reg <= scl_f_next;
			sda_f_reg <= sda_f_next;
			scl_p_reg <= scl_f_reg;
			sda_p_reg <= sda_f_reg;
		end
	end
	// Bus events from the filtered levels.
	assign scl_rise = scl_f_reg && !scl_p_reg;
	assign scl_fall = !scl_f_reg && scl_p_reg;
	// Data moving while the clock stays high is a condition, not a bit.
	assign start_ev = scl_f_reg && scl_p_reg && sda_p_reg && !sda_f_reg; // RL1 RL8
	assign stop_ev = scl_f_reg && scl_p_reg && !sda_p_reg && sda_f_reg; // RL2 RL8
	// Transfer sequencer. Conditions override any bit in flight.
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		ptr_next = ptr_reg;
		first_next = first_reg;
		rd_next = rd_reg;
		ptrph_next = ptrph_reg;
		wrote_next = wrote_reg;
		mack_next = mack_reg;
		drive_next = drive_reg;
		we_next = 1'b0;
		re_next = 1'b0;
		wdata_next = wdata_reg;
		busy_next = busy_reg;
		load_tx = 1'b0;
		if (stop_ev) begin
			st_next = T_IDLE; // RL2 RL21
			drive_next = 1'b0;
			busy_next = 1'b0;
		end else if (start_ev) begin
			st_next = T_RX; // RL1 RL3 RL21
			first_next = 1'b1; // RL3
			cnt_next = 4'h0; // RL21
			drive_next = 1'b0;
			busy_next = 1'b1;
		end else begin
			case (st_reg)
			T_IDLE: begin
				drive_next = 1'b0;
			end
			T_RX: begin
				if (scl_rise) begin
					// Sample while clock is high, most significant bit first.
					sh_next = {sh_reg[6:0], sda_f_reg}; // RL4 RL7
					cnt_next = cnt_reg + 4'h1;
				end else if (scl_fall && cnt_reg == RTI_BYTE_BITS) begin
					wrote_next = 1'b0;
					if (first_reg) begin
						if (sh_reg[7:1] == OWN_ADDR) begin // RL14 RL15
							rd_next = (sh_reg[0] == RTI_DIR_READ); // RL16
							ptrph_next = (sh_reg[0] != RTI_DIR_READ); // RL19
							first_next = 1'b0;
							drive_next = 1'b1; // RL9 RL10
							st_next = T_ACK;
						end else begin
							// Not ours: stay off the bus until next condition.
							st_next = T_IDLE; // RL14
						end
					end else if (ptrph_reg) begin
						ptr_next = sh_reg; // RL19
						ptrph_next = 1'b0;
						drive_next = 1'b1; // RL9
						st_next = T_ACK;
					end else begin
						we_next = 1'b1; // RL19
						wdata_next = sh_reg;
						wrote_next = 1'b1;
						drive_next = 1'b1; // RL9
						st_next = T_ACK;
					end
				end
			end
			T_ACK: begin
				if (scl_fall) begin
					drive_next = 1'b0;
					cnt_next = 4'h0;
					if (wrote_reg) begin
						ptr_next = ptr_reg + 8'h01; // RL6 RL19
					end
					if (rd_reg) begin
						load_tx = 1'b1; // RL20
					end else begin
						st_next = T_RX; // RL5
					end
				end
			end
			T_TX: begin
				if (scl_fall) begin
					if (cnt_reg == RTI_BYTE_BITS - 4'h1) begin
						drive_next = 1'b0; // RL10
						st_next = T_RACK;
					end else begin
						// Next bit goes out only while the clock is low.
						sh_next = {sh_reg[6:0], 1'b0}; // RL4 RL7
						drive_next = !sh_reg[6];
						cnt_next = cnt_reg + 4'h1;
					end
				end
			end
			T_RACK: begin
				if (scl_rise) begin
					mack_next = !sda_f_reg; // RL9
				end else if (scl_fall) begin
					if (mack_reg) begin
						load_tx = 1'b1; // RL11 RL5
					end else begin
						// Master is done; keep the line released.
						drive_next = 1'b0; // RL12 RL13
						st_next = T_IDLE; // RL13
					end
				end
			end
			default: begin
				st_next = T_IDLE;
				drive_next = 1'b0;
			end
			endcase
		end
		// Fetch the byte at the pointer and put its top bit out at once.
		if (load_tx) begin
			sh_next = mem_rdata_i; // RL20
			re_next = 1'b1;
			ptr_next = ptr_reg + 8'h01; // RL6
			drive_next = !mem_rdata_i[7]; // RL11
			cnt_next = 4'h0;
			st_next = T_TX;
		end
	end
	// The pointer is kept across transactions so a bare read resumes.
	always_ff @(posedge lclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_reg <= T_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			ptr_reg <= 8'h00;
			first_reg <= 1'b0;
			rd_reg <= 1'b0;
			ptrph_reg <= 1'b0;
			wrote_reg <= 1'b0;
			mack_reg <= 1'b0;
			drive_reg <= 1'b0;
			we_reg <= 1'b0;
			re_reg <= 1'b0;
			wdata_reg <= 8'h00;
			busy_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			ptr_reg <= ptr_next;
			first_reg <= first_next;
			rd_reg <= rd_next;
			ptrph_reg <= ptrph_next;
			wrote_reg <= wrote_next;
			mack_reg <= mack_next;
			drive_reg <= drive_next;
			we_reg <= we_next;
			re_reg <= re_next;
			wdata_reg <= wdata_next;
			busy_reg <= busy_next;
		end
	end
	// Open-drain: only ever pull low, release otherwise.
	assign bus.t_sda_o = 1'b0; // RL18
	assign bus.t_sda_oe = drive_reg; // RL18
	assign mem_addr_o = ptr_reg;
	assign mem_wdata_o = wdata_reg;
	assign mem_we_o = we_reg;
	assign mem_re_o = re_reg;
	assign busy_o = busy_reg;
endmodule
`default_nettype wire

// File: verif/rti_link_asserts.sv
// Checker watching the two-wire bus between the master and target ends.
// Assumes the bench ties it to the bus interface signals by name.
`timescale 1ns/1ps
`default_nettype none
module rti_link_chk
	import rti_pkg::*;
#(
	parameter logic [6:0] OWN_ADDR = RTI_TARGET_ADDR
) (
	input wire logic mclk_i, // Master clock.
	input wire logic lclk_i, // Link clock.
	input wire logic rstn_i, // Reset, active low.
	input wire logic m_scl_o, // Master SCL drive value.
	input wire logic m_sda_o, // Master SDA drive value.
	input wire logic t_sda_o, // Target SDA drive value.
	input wire logic t_sda_oe, // Target pulls SDA low.
	input wire logic scl, // Resolved SCL.
	input wire logic sda // Resolved SDA.
);
	typedef struct packed {
		logic scl;
		logic sda;
		logic first;
		logic wr;
		logic rd;
		logic quiet;
		logic [3:0] cnt;
		logic [7:0] sh;
	} rti_chk_s;
	rti_chk_s s_reg, s_next;
	logic rise, fall, st, sp, match;

	// Line events; a condition needs SCL high on both samples.
	assign rise = scl && !s_reg.scl;
	assign fall = !scl && s_reg.scl;
	assign st = scl && s_reg.scl && s_reg.sda && !sda;
	assign sp = scl && s_reg.scl && !s_reg.sda && sda;
	assign match = s_reg.sh[7:1] == OWN_ADDR;

	// Bit counter 1..9 per byte; the ninth bit is not shifted in.
	always_comb begin
		s_next = s_reg;
		s_next.scl = scl;
		s_next.sda = sda;
		if (st || sp) begin
			s_next = '{scl: scl, sda: sda, first: st, default: '0};
		end else if (rise) begin
			s_next.cnt = (s_reg.cnt == 4'h9) ? 4'h1 : s_reg.cnt + 4'h1;
			if (s_reg.cnt != 4'h8)
				s_next.sh = {s_reg.sh[6:0], sda};
		end else if (fall && s_reg.cnt == 4'h9) begin
			s_next.first = 1'h0;
			if (s_reg.first) begin
				s_next.wr = match && !s_reg.sh[0];
				s_next.rd = match && s_reg.sh[0];
				s_next.quiet = !match;
			end else if (s_reg.rd && s_reg.sda) begin
				s_next.quiet = 1'h1;
			end
		end
	end

	// Released lines read high, so the state starts as an idle bus.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			s_reg <= '{scl: 1'h1, sda: 1'h1, default: '0};
		else
			s_reg <= s_next;
	end

	sequence start_s;
		scl && s_reg.scl && s_reg.sda && !sda;
	endsequence
	sequence stop_s;
		scl && s_reg.scl && !s_reg.sda && sda;
	endsequence
	// SCL high on both samples keeps out the rise that opens the next byte.
	sequence ack_s(logic c);
		s_reg.cnt == 4'h9 && s_reg.scl && scl && c;
	endsequence

	chk_pull_low_only: assert property (@(posedge mclk_i)
		disable iff (!rstn_i) !m_scl_o && !m_sda_o && !t_sda_o)
		else $error("a bus end drives a line high");
	chk_target_change_low: assert property (@(posedge lclk_i)
		disable iff (!rstn_i) $changed(t_sda_oe) |-> !scl)
		else $error("target moved SDA while SCL high");
	chk_target_hold_high: assert property (@(posedge lclk_i)
		disable iff (!rstn_i) $rose(scl) && t_sda_oe |-> t_sda_oe [*8])
		else $error("target let go of SDA during SCL high");
	chk_start_shape: assert property (@(posedge mclk_i)
		disable iff (!rstn_i) start_s |-> scl [*8])
		else $error("SCL fell too soon after a start");
	chk_stop_idle: assert property (@(posedge mclk_i)
		disable iff (!rstn_i) stop_s |-> (scl && sda) [*8])
		else $error("bus not idle after a stop");
	chk_addr_acked: assert property (@(posedge mclk_i)
		disable iff (!rstn_i) ack_s(s_reg.first && match) |-> !sda)
		else $error("own address not acknowledged");
	chk_foreign_ignored: assert property (@(posedge mclk_i)
		disable iff (!rstn_i) ack_s(s_reg.first && !match) |-> sda)
		else $error("foreign address acknowledged");
	chk_data_acked: assert property (@(posedge mclk_i)
		disable iff (!rstn_i) ack_s(!s_reg.first && s_reg.wr) |-> !sda)
		else $error("written byte not acknowledged");
	chk_target_silent: assert property (@(posedge mclk_i)
		disable iff (!rstn_i) s_reg.quiet |-> !t_sda_oe)
		else $error("target drove SDA while it should be idle");
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench: master and target ends joined by the bus.
// Assumes package, interface, both ends and the checker compile first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rti_pkg::*;
	logic mclk_i, lclk_i, rstn_i, cmd_valid, cmd_ack, r_nack;
	logic mem_we, mem_re, busy, cmd_ready, rsp_valid, rsp_nack;
	logic [7:0] cmd_data, r_data, ptr, rsp_data;
	logic [7:0] mem_addr, mem_wdata, mem_rdata;
	logic [7:0] mem [256];
	logic [7:0] exp_mem [256];
	rti_cmd_e cmd;
	int n_fail, check_count, n_re;
	rti_bus_if bus ();

	// System clock, 5 ns.
	initial begin
		mclk_i = 1'h0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	// Link clock, 15 ns, offset so its edges never meet the other clock.
	initial begin
		lclk_i = 1'h0;
		#1.3;
		forever #7.5 lclk_i = ~lclk_i;
	end

	// Target memory: combinational read, store on the strobe.
	assign mem_rdata = mem[mem_addr];
	always @(posedge lclk_i)
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
	// Fetch strobes seen, so each read can be held to one fetch a byte.
	always @(posedge lclk_i)
		if (mem_re)
			n_re++;

	// Short quarters keep the run brief yet leave the link time to sample.
	rti_master #(.QTR_CYC(16'h0018)) i_rti_master (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .bus(bus),
		.cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_data_i(cmd_data),
		.cmd_ack_i(cmd_ack), .cmd_ready_o(cmd_ready),
		.rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
		.rsp_nack_o(rsp_nack));
	rti_target i_rti_target (
		.lclk_i(lclk_i), .rstn_i(rstn_i), .bus(bus),
		.mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_we_o(mem_we),
		.mem_re_o(mem_re), .mem_rdata_i(mem_rdata), .busy_o(busy));
	rti_link_chk #(.OWN_ADDR(RTI_TARGET_ADDR)) i_rti_link_chk (
		.mclk_i(mclk_i), .lclk_i(lclk_i), .rstn_i(rstn_i),
		.m_scl_o(bus.m_scl_o), .m_sda_o(bus.m_sda_o),
		.t_sda_o(bus.t_sda_o), .t_sda_oe(bus.t_sda_oe),
		.scl(bus.scl), .sda(bus.sda));

	// Pointer step; wraps from the top location to zero.
	function automatic logic [7:0] nxt(input logic [7:0] a);
		return a + 8'h01;
	endfunction

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] want);
		check_count++;
		if (got !== want) begin
			n_fail++;
			$display("unexpected at %0t: byte %h not %h", $time, got, want);
		end
	endtask

	task automatic chk1(input logic got, input logic want);
		check_count++;
		if (got !== want) begin
			n_fail++;
			$display("unexpected at %0t: flag %b not %b", $time, got, want);
		end
	endtask

	// One command: hold it until taken, then wait for the answer.
	task automatic op(input rti_cmd_e c, input logic [7:0] d, input logic a);
		int t;
		t = 0;
		@(negedge mclk_i);
		cmd_valid = 1'h1;
		cmd = c;
		cmd_data = d;
		cmd_ack = a;
		do
			@(posedge mclk_i);
		while (cmd_ready !== 1'h1 && ++t < 2000);
		@(negedge mclk_i);
		cmd_valid = 1'h0;
		do
			@(posedge mclk_i);
		while (rsp_valid !== 1'h1 && ++t < 4000);
		if (t >= 4000) begin
			n_fail++;
			$display("unexpected at %0t: command never answered", $time);
			wrap_up();
		end
		r_data = rsp_data;
		r_nack = rsp_nack;
	endtask

	task automatic wr_burst(input logic [7:0] p, input int n);
		logic [7:0] b;
		op(RTI_CMD_START, 8'h00, 1'h0);
		chk1(busy, 1'h1);
		op(RTI_CMD_WRITE, {RTI_TARGET_ADDR, 1'h0}, 1'h0);
		chk1(r_nack, 1'h0);
		op(RTI_CMD_WRITE, p, 1'h0);
		chk1(r_nack, 1'h0);
		for (int i = 0; i < n; i++) begin
			b = 8'($urandom);
			exp_mem[p] = b;
			op(RTI_CMD_WRITE, b, 1'h0);
			chk1(r_nack, 1'h0);
			p = nxt(p);
		end
		op(RTI_CMD_STOP, 8'h00, 1'h0);
		chk1(busy, 1'h0);
		ptr = p;
		for (int i = 0; i < 256; i++)
			chk8(mem[i], exp_mem[i]);
		$display("test write of %0d bytes done", n);
	endtask

	task automatic rd_burst(input logic set, input logic [7:0] p, input int n);
		int r0;
		r0 = n_re;
		op(RTI_CMD_START, 8'h00, 1'h0);
		if (set) begin
			op(RTI_CMD_WRITE, {RTI_TARGET_ADDR, 1'h0}, 1'h0);
			op(RTI_CMD_WRITE, p, 1'h0);
			op(RTI_CMD_START, 8'h00, 1'h0);
			chk1(busy, 1'h1);
		end
		op(RTI_CMD_WRITE, {RTI_TARGET_ADDR, 1'h1}, 1'h0);
		chk1(r_nack, 1'h0);
		for (int i = 0; i < n; i++) begin
			op(RTI_CMD_READ, 8'h00, i != n - 1);
			chk8(r_data, exp_mem[p]);
			p = nxt(p);
		end
		op(RTI_CMD_STOP, 8'h00, 1'h0);
		chk8(8'(n_re - r0), 8'(n));
		ptr = p;
		$display("test read of %0d bytes done", n);
	endtask

	initial begin
		logic [7:0] p;
		int n;
		rstn_i = 1'h0;
		cmd_valid = 1'h0;
		cmd = RTI_CMD_START;
		cmd_data = 8'h00;
		cmd_ack = 1'h0;
		n_fail = 0;
		check_count = 0;
		n_re = 0;
		ptr = 8'h00;
		void'($urandom(32'hdc1a));
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i * 7);
			exp_mem[i] = 8'(i * 7);
		end
		repeat (6) @(posedge mclk_i);
		@(negedge mclk_i);
		rstn_i = 1'h1;
		// Random bursts above the test locations, each read back once, then one bare read at the pointer.
		repeat (3) begin
			p = 8'h4b + 8'($urandom % 160);
			n = 1 + $urandom % 4;
			wr_burst(p, n);
			rd_burst(1'h1, p, n);
			rd_burst(1'h0, ptr, 1);
		end
		wr_burst(8'hfe, 3);
		rd_burst(1'h1, 8'hfe, 3);
		// A foreign address must see no answer and a released line.
		op(RTI_CMD_START, 8'h00, 1'h0);
		op(RTI_CMD_WRITE, {RTI_TARGET_ADDR ^ 7'h01, 1'h1}, 1'h0);
		chk1(r_nack, 1'h1);
		op(RTI_CMD_READ, 8'h00, 1'h0);
		chk8(r_data, 8'hff);
		op(RTI_CMD_STOP, 8'h00, 1'h0);
		$display("test foreign address done");
		wrap_up();
	end
endmodule
`default_nettype wire
